// >>> hw/iat_pkg.sv
// constants and types shared by the instruction address translation block
package iat_pkg;
  localparam int ENTRY_COUNT = 4;
  localparam int ADDRESS_SPACE_IDENTIFIER_W = 8;
  localparam int VPN_W = 22;
  localparam int PPN_W = 19;
  localparam int PAGE_LSB = 10;
  localparam int VA_W = 32;
  localparam int PA_W = 29;

  // page size codes and the offset bits from bit 10 upward that each one covers
  localparam logic [1:0] SIZE_1K = 2'h0;
  localparam logic [1:0] SIZE_4K = 2'h1;
  localparam logic [1:0] SIZE_64K = 2'h2;
  localparam logic [1:0] SIZE_1M = 2'h3;
  localparam logic [21:0] OFS_MASK_1K = 22'h000000;
  localparam logic [21:0] OFS_MASK_4K = 22'h000003;
  localparam logic [21:0] OFS_MASK_64K = 22'h00003f;
  localparam logic [21:0] OFS_MASK_1M = 22'h0003ff;

  // register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_MISS_ADDR = 4'h8;

  // control register fields
  localparam int CTRL_ADDRESS_SPACE_IDENTIFIER_LSB = 0;
  localparam int CTRL_INVAL_BIT = 8;
  localparam logic [7:0] CTRL_ADDRESS_SPACE_IDENTIFIER_RESET = 8'h00;

  // status register fields
  localparam int STAT_PTR_LSB = 0;
  localparam int STAT_VALID_LSB = 4;
  localparam int STAT_PEND_BIT = 8;

  typedef enum logic [0:0] {
    IAT_IDLE,
    IAT_REFILL
  } iat_state_t;

  function automatic logic [21:0] iat_ofs_mask(input logic [1:0] size);
    case (size)
      SIZE_1K: iat_ofs_mask = OFS_MASK_1K;
      SIZE_4K: iat_ofs_mask = OFS_MASK_4K;
      SIZE_64K: iat_ofs_mask = OFS_MASK_64K;
      default: iat_ofs_mask = OFS_MASK_1M;
    endcase
  endfunction
endpackage

// >>> hw/iat_entry_match.sv
// tag compare of one translation entry against a fetch address
`timescale 1ns/10ps
module iat_entry_match (
  input wire logic entry_valid, // entry holds a translation
  input wire logic [7:0] entry_address_space_identifier, // entry address space identifier
  input wire logic [21:0] entry_vpn, // entry virtual page number
  input wire logic entry_shared, // entry shared flag
  input wire logic [1:0] entry_size, // entry page size code
  input wire logic [7:0] cur_address_space_identifier, // current address space identifier
  input wire logic [21:0] fetch_vpn, // fetch address bits 31 to 10
  output logic match // entry translates this fetch
);
  logic [21:0] ofs;
  logic vpn_eq;
  logic address_space_identifier_ok;

  always_comb begin
    ofs = iat_pkg::iat_ofs_mask(entry_size);
    // offset bits inside a large page take no part in the compare
    vpn_eq = ((entry_vpn ^ fetch_vpn) & ~ofs) == 22'h000000;
    address_space_identifier_ok = entry_shared || (entry_address_space_identifier == cur_address_space_identifier);
    match = entry_valid && vpn_eq && address_space_identifier_ok;
  end
endmodule

// >>> hw/iat_translation_buffer.sv
// instruction fetch translation buffer with refill port and register slave
//
// Our own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
module iat_translation_buffer #(
  parameter int ENTRIES = iat_pkg::ENTRY_COUNT
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // asynchronous reset, active high
  input wire logic fetch_valid, // fetch address offered
  output logic fetch_ready, // buffer accepts a fetch
  input wire logic [31:0] fetch_vaddr, // fetch virtual address
  output logic fetch_done, // lookup result pulse
  output logic fetch_hit, // lookup found a translation
  output logic [28:0] fetch_paddr, // translated physical address
  output logic fetch_cacheable, // page is cacheable
  output logic fetch_prot, // page protection bit
  output logic refill_req, // refill wanted from unified table
  output logic [31:0] refill_vaddr, // address that missed
  output logic [7:0] refill_address_space_identifier, // current address space identifier, not latched at the miss
  input wire logic refill_valid, // unified table answer strobe
  input wire logic [7:0] refill_tag_address_space_identifier, // entry identifier
  input wire logic [21:0] refill_vpn, // entry virtual page number
  input wire logic [18:0] refill_ppn, // entry physical page number
  input wire logic [1:0] refill_size, // entry page size code
  input wire logic refill_shared, // entry shared flag
  input wire logic refill_cacheable, // entry cacheable flag
  input wire logic [1:0] refill_prot, // table protection field
  input wire logic [3:0] avs_address, // register byte address
  input wire logic avs_read, // register read request
  input wire logic avs_write, // register write request
  input wire logic [31:0] avs_writedata, // register write data
  input wire logic [3:0] avs_byteenable, // write byte lanes
  output logic [31:0] avs_readdata, // register read data
  output logic avs_waitrequest // request not yet answered
);
  localparam int PW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

  // entry store; dirty and write-through are deliberately absent
  logic [ENTRIES-1:0] valid, next_valid;
  logic [7:0] address_space_identifier_mem [ENTRIES];
  logic [21:0] vpn_mem [ENTRIES];
  logic [18:0] ppn_mem [ENTRIES];
  logic [1:0] size_mem [ENTRIES];
  logic [ENTRIES-1:0] shared_mem, cache_mem, prot_mem;
  logic [PW-1:0] fill_ptr, next_fill_ptr;
  logic [ENTRIES-1:0] match;

  iat_pkg::iat_state_t state, next_state;
  logic [7:0] cur_address_space_identifier, next_cur_address_space_identifier;
  logic [31:0] miss_addr, next_miss_addr;
  logic done, next_done;
  logic hit, next_hit;
  logic [28:0] paddr, next_paddr;
  logic cach, next_cach;
  logic prot, next_prot;
  logic ack, next_ack;
  logic [31:0] rdata, next_rdata;
  logic inval;

  // one comparator per entry: any translation may sit anywhere
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g++) begin : g_ent
      iat_entry_match u_match (
        .entry_valid(valid[g]),
        .entry_address_space_identifier(address_space_identifier_mem[g]),
        .entry_vpn(vpn_mem[g]),
        .entry_shared(shared_mem[g]),
        .entry_size(size_mem[g]),
        .cur_address_space_identifier(cur_address_space_identifier),
        .fetch_vpn(fetch_vaddr[31:10]),
        .match(match[g])
      );
    end
  endgenerate

  // lookup and refill sequencing
  always_comb begin
    logic [21:0] ofs;
    logic found;
    ofs = 22'h000000;
    found = 1'b0;
    next_state = state;
    next_miss_addr = miss_addr;
    next_done = 1'b0;
    next_hit = hit;
    next_paddr = paddr;
    next_cach = cach;
    next_prot = prot;
    next_valid = valid;
    next_fill_ptr = fill_ptr;
    if (inval) begin
      next_valid = '0;
    end
    case (state)
      iat_pkg::IAT_IDLE: begin
        if (fetch_valid) begin
          next_done = 1'b1;
          next_hit = 1'b0;
          // lowest matching entry wins if software left duplicates
          for (int i = ENTRIES - 1; i >= 0; i--) begin
            if (match[i]) begin
              found = 1'b1;
              ofs = iat_pkg::iat_ofs_mask(size_mem[i]);
              next_paddr = {(ppn_mem[i] & ~ofs[18:0])
                            | (fetch_vaddr[28:10] & ofs[18:0]),
                            fetch_vaddr[9:0]};
              next_cach = cache_mem[i];
              next_prot = prot_mem[i];
            end
          end
          next_hit = found;
          if (!found) begin
            next_miss_addr = fetch_vaddr;
            next_state = iat_pkg::IAT_REFILL;
          end
        end
      end
      iat_pkg::IAT_REFILL: begin
        if (refill_valid) begin
          // refill beats a same-cycle invalidate for the written entry
          next_valid[fill_ptr] = 1'b1;
          next_fill_ptr = PW'((ENTRIES == 1) ? 0 : fill_ptr + 1'b1);
          next_state = iat_pkg::IAT_IDLE;
        end
      end
      default: next_state = iat_pkg::IAT_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= iat_pkg::IAT_IDLE;
      miss_addr <= 32'h00000000;
      done <= 1'b0;
      hit <= 1'b0;
      paddr <= 29'h00000000;
      cach <= 1'b0;
      prot <= 1'b0;
      valid <= '0;
      fill_ptr <= '0;
    end else begin
      state <= next_state;
      miss_addr <= next_miss_addr;
      done <= next_done;
      hit <= next_hit;
      paddr <= next_paddr;
      cach <= next_cach;
      prot <= next_prot;
      valid <= next_valid;
      fill_ptr <= next_fill_ptr;
    end
  end

  // entry payload needs no reset: valid guards every use of it
  always_ff @(posedge clk_sys) begin
    if (state == iat_pkg::IAT_REFILL && refill_valid) begin
      address_space_identifier_mem[fill_ptr] <= refill_tag_address_space_identifier;
      vpn_mem[fill_ptr] <= refill_vpn;
      ppn_mem[fill_ptr] <= refill_ppn;
      size_mem[fill_ptr] <= refill_size;
      shared_mem[fill_ptr] <= refill_shared;
      cache_mem[fill_ptr] <= refill_cacheable;
      prot_mem[fill_ptr] <= refill_prot[1];
    end
  end

  // register slave: one wait cycle, then answer from flip-flops;
  // a write lands only on the edge that completes the transfer
  always_comb begin
    next_ack = (avs_read || avs_write) && !ack;
    next_rdata = rdata;
    next_cur_address_space_identifier = cur_address_space_identifier;
    inval = 1'b0;
    if (avs_read && !ack) begin
      case (avs_address)
        iat_pkg::REG_CTRL: next_rdata = {24'h000000, cur_address_space_identifier};
        iat_pkg::REG_STATUS: begin
          next_rdata = 32'h00000000;
          next_rdata[iat_pkg::STAT_PTR_LSB +: PW] = fill_ptr;
          next_rdata[iat_pkg::STAT_VALID_LSB +: ENTRIES] = valid;
          next_rdata[iat_pkg::STAT_PEND_BIT] =
            (state == iat_pkg::IAT_REFILL);
        end
        iat_pkg::REG_MISS_ADDR: next_rdata = miss_addr;
        default: next_rdata = 32'h00000000;
      endcase
    end
    if (avs_write && ack && avs_address == iat_pkg::REG_CTRL) begin
      if (avs_byteenable[0]) begin
        next_cur_address_space_identifier = avs_writedata[iat_pkg::CTRL_ADDRESS_SPACE_IDENTIFIER_LSB +: 8];
      end
      if (avs_byteenable[1]) begin
        inval = avs_writedata[iat_pkg::CTRL_INVAL_BIT];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ack <= 1'b0;
      rdata <= 32'h00000000;
      cur_address_space_identifier <= iat_pkg::CTRL_ADDRESS_SPACE_IDENTIFIER_RESET;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
      cur_address_space_identifier <= next_cur_address_space_identifier;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign avs_readdata = rdata;
  assign fetch_ready = (state == iat_pkg::IAT_IDLE);
  assign fetch_done = done;
  assign fetch_hit = hit;
  assign fetch_paddr = paddr;
  assign fetch_cacheable = cach;
  assign fetch_prot = prot;
  assign refill_req = (state == iat_pkg::IAT_REFILL);
  assign refill_vaddr = miss_addr;
  assign refill_address_space_identifier = cur_address_space_identifier;
endmodule

// >>> sim/iat_utt_model.sv
// unified translation table model answering refill requests
`timescale 1ns/10ps
module iat_utt_model (
  input wire logic clk_sys, // clock
  input wire logic reset, // async reset
  input wire logic refill_req, // refill wanted
  input wire logic [31:0] refill_vaddr, // missed address
  input wire logic [7:0] refill_address_space_identifier, // current identifier
  output logic refill_valid, // answer strobe
  output logic [7:0] refill_tag_address_space_identifier, // entry identifier
  output logic [21:0] refill_vpn, // entry page
  output logic [18:0] refill_ppn, // physical page
  output logic [1:0] refill_size, // size code
  output logic refill_shared, // shared flag
  output logic refill_cacheable, // cacheable flag
  output logic [1:0] refill_prot // protection field
);
  logic [3:0] cnt;
  logic slow;
  logic [54:0] ent;
  // fields derive from the address so the bench can predict them
  assign ent = {refill_address_space_identifier, refill_vaddr[31:10], ~refill_vaddr[28:10],
    refill_vaddr[31:27], ~refill_vaddr[27]};
  // lines show the inverse outside the strobe, never a stale entry
  assign {refill_tag_address_space_identifier, refill_vpn, refill_ppn, refill_size,
    refill_shared, refill_cacheable, refill_prot} = refill_valid ? ent : ~ent;
  // answers alternate between prompt and slow
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt <= 4'h0;
      slow <= 1'b0;
      refill_valid <= 1'b0;
    end else if (refill_valid) begin
      refill_valid <= 1'b0;
      slow <= ~slow;
      cnt <= 4'h0;
    end else if (refill_req) begin
      cnt <= cnt + 4'h1;
      refill_valid <= (cnt == (slow ? 4'h5 : 4'h0));
    end
  end
endmodule

// >>> sim/iat_translation_buffer_chk.sv
// port assertions for the translation buffer
`timescale 1ns/10ps
module iat_chk (
  input wire logic clk_sys, // clock
  input wire logic reset, // async reset
  input wire logic fetch_valid, // fetch offered
  input wire logic fetch_ready, // fetch accepted
  input wire logic [31:0] fetch_vaddr, // fetch address
  input wire logic fetch_done, // lookup pulse
  input wire logic fetch_hit, // lookup hit
  input wire logic refill_req, // refill wanted
  input wire logic [31:0] refill_vaddr, // missed address
  input wire logic refill_valid, // table answer
  input wire logic avs_read, // bus read
  input wire logic avs_write, // bus write
  input wire logic avs_waitrequest // bus stall
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_take;
    fetch_valid && fetch_ready;
  endsequence
  sequence s_miss;
    fetch_done && !fetch_hit;
  endsequence
  a_done_after_take: assert property (s_take |=> fetch_done)
    else $error("no lookup result after fetch");
  a_no_stray_done: assert property (!(fetch_valid && fetch_ready) |=>
    !fetch_done) else $error("lookup result without fetch");
  a_miss_refills: assert property (s_miss |-> refill_req)
    else $error("miss without refill request");
  a_miss_address: assert property ($rose(refill_req) |->
    refill_vaddr == $past(fetch_vaddr)) else $error("wrong miss address");
  a_refill_ends: assert property (refill_req && refill_valid |=>
    !refill_req ##0 fetch_ready) else $error("refill not closed");
  a_refill_waits: assert property (refill_req && !refill_valid |=>
    refill_req) else $error("refill request dropped early");
  a_hit_no_refill: assert property (fetch_done && fetch_hit |->
    fetch_ready && !refill_req) else $error("refill started on a hit");
  a_one_wait: assert property ((avs_read || avs_write) &&
    avs_waitrequest |=> !avs_waitrequest) else $error("bus not answered");
endmodule
bind iat_translation_buffer iat_chk u_chk (.clk_sys, .reset, .fetch_valid,
  .fetch_ready, .fetch_vaddr, .fetch_done, .fetch_hit, .refill_req,
  .refill_vaddr, .refill_valid, .avs_read, .avs_write, .avs_waitrequest);

// >>> sim/iat_translation_buffer_tb.sv
// self-checking bench for the translation buffer
`timescale 1ns/10ps
module iat_translation_buffer_tb;
  logic clk_sys, reset, fetch_valid, fetch_ready, fetch_done, fetch_hit;
  logic fetch_cacheable, fetch_prot, refill_req, refill_valid;
  logic refill_shared, refill_cacheable, avs_read, avs_write;
  logic avs_waitrequest;
  logic [31:0] fetch_vaddr, refill_vaddr, avs_writedata, avs_readdata, rd, b;
  logic [28:0] fetch_paddr;
  logic [21:0] refill_vpn;
  logic [18:0] refill_ppn, m;
  logic [7:0] refill_address_space_identifier, refill_tag_address_space_identifier;
  logic [1:0] refill_size, refill_prot;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] adr [5];
  int error_cnt, tests_run, cyc;
  iat_translation_buffer dut (.clk_sys, .reset, .fetch_valid, .fetch_ready,
    .fetch_vaddr, .fetch_done, .fetch_hit, .fetch_paddr, .fetch_cacheable,
    .fetch_prot, .refill_req, .refill_vaddr, .refill_address_space_identifier, .refill_valid,
    .refill_tag_address_space_identifier, .refill_vpn, .refill_ppn, .refill_size, .refill_shared,
    .refill_cacheable, .refill_prot, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
  iat_utt_model utt (.clk_sys, .reset, .refill_req, .refill_vaddr,
    .refill_address_space_identifier, .refill_valid, .refill_tag_address_space_identifier, .refill_vpn, .refill_ppn,
    .refill_size, .refill_shared, .refill_cacheable, .refill_prot);
  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic summarize;
    if (error_cnt == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic av(input logic w, input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk_sys);
    avs_read <= ~w;
    avs_write <= w;
    avs_address <= ad;
    avs_writedata <= d;
    // hold the request until waitrequest is seen low at a rising edge
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
  endtask
  task automatic fetch(input logic [31:0] a, input logic eh);
    @(posedge clk_sys);
    fetch_valid <= 1;
    fetch_vaddr <= a;
    @(posedge clk_sys);
    fetch_valid <= 0;
    @(negedge clk_sys);
    check("done", fetch_done, 1);
    check("hit", fetch_hit, eh);
    if (!eh) begin
      check("miss address", refill_vaddr, a);
      while (fetch_ready !== 1'b1) @(negedge clk_sys);
    end
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    reset = 1;
    fetch_valid = 0;
    fetch_vaddr = 0;
    avs_read = 0;
    avs_write = 0;
    avs_address = 0;
    avs_writedata = 0;
    avs_byteenable = 4'hf;
    error_cnt = 0;
    tests_run = 0;
    cyc = 0;
    // size code, shared, cacheable, protection sit in address bits 31:27
    adr = '{32'h00001234, 32'h48005678, 32'ha0009abc, 32'hf0003def,
      32'h18000400};
    repeat (2) @(posedge clk_sys);
    reset <= 0;
    av(0, 4'h0, 0);
    check("ctrl", rd, 0);
    av(0, 4'h4, 0);
    check("status", rd, 0);
    av(0, 4'hc, 0);
    check("unmapped", rd, 0);
    av(1, 4'h0, 32'h5a);
    for (int i = 0; i < 5; i++) begin
      fetch(adr[i], 0);
      m = adr[i][31:30] == 2'h0 ? 19'h0 : adr[i][31:30] == 2'h1 ? 19'h3 :
        adr[i][31:30] == 2'h2 ? 19'h3f : 19'h3ff;
      b = adr[i] ^ {3'h0, m, 10'h3ff};
      fetch(b, 1);
      check("paddr", fetch_paddr,
        {(~adr[i][28:10] & ~m) | (b[28:10] & m), b[9:0]});
      check("cacheable", fetch_cacheable, adr[i][28]);
      check("prot", fetch_prot, adr[i][27]);
    end
    av(0, 4'h8, 0);
    check("miss reg", rd, adr[4]);
    av(0, 4'h4, 0);
    check("status", rd, 32'hf1);
    fetch(adr[0], 0);
    av(1, 4'h0, 32'h11);
    fetch(adr[2], 1);
    fetch(adr[4], 0);
    // the new entry must carry the identifier now in force
    fetch(adr[4], 1);
    av(1, 4'h0, 32'h111);
    av(0, 4'h0, 0);
    check("ctrl after inval", rd, 32'h11);
    av(0, 4'h4, 0);
    check("valid bits", rd[8:4], 0);
    fetch(adr[3], 0);
    summarize();
  end
endmodule
